// ---- fsm_map.svh ----
// register offsets, field positions, reset values and store sizes for the fifo/clock mode block
`ifndef FSM_MAP_SVH
`define FSM_MAP_SVH
`define FSM_OFS_CTRL_A 8'h00
`define FSM_OFS_CTRL_B 8'h04
`define FSM_OFS_CTRL_C 8'h08
`define FSM_OFS_CTRL_D 8'h0C
`define FSM_OFS_STATUS 8'h10
`define FSM_OFS_SYNC 8'h14
`define FSM_A_FIFO_ENA 0
`define FSM_A_OFFSET_LO 4
`define FSM_A_OFFSET_HI 6
`define FSM_A_RESET 32'h0000_0041
`define FSM_B_PLL_ENA 0
`define FSM_B_CP_LO 4
`define FSM_B_CP_HI 5
`define FSM_B_PRE_LO 8
`define FSM_B_PRE_HI 10
`define FSM_B_M_LO 16
`define FSM_B_M_HI 23
`define FSM_B_RESET 32'h0004_0710
`define FSM_C_PLL_SLEEP 0
`define FSM_C_VCO_LO 8
`define FSM_C_VCO_HI 13
`define FSM_C_N_LO 16
`define FSM_C_N_HI 23
`define FSM_C_RESET 32'h0001_0001
`define FSM_D_OUT_LO 0
`define FSM_D_OUT_HI 3
`define FSM_D_IN_LO 4
`define FSM_D_IN_HI 7
`define FSM_D_RESET 32'h0000_0022
`define FSM_SEL_SIF 3
`define FSM_SEL_OUTPUT_PHASE_STROBE 2
`define FSM_SEL_INPUT_PHASE_STROBE 1
`define FSM_SEL_SYNC 0
`define FSM_ST_COLL 0
`define FSM_ST_ONE 1
`define FSM_ST_TWO 2
`define FSM_ST_MODE_LO 4
`define FSM_ST_PLLSRC 6
`define FSM_DEPTH 8
`define FSM_ADDR_W 3
`define FSM_DATA_W 64
`endif

// ---- fsm_pkg.sv ----
// types shared by the fifo/clock mode block
package fsm_pkg;
  typedef enum logic [1:0] {FsmBypass, FsmSingle, FsmDual, FsmNoSync} fsm_mode_t;
  typedef struct packed {
    logic collision;
    logic oneAway;
    logic twoAway;
  } fsm_alarm_t;
  typedef struct packed {
    logic sif;
    logic outStrobe;
    logic inStrobe;
    logic syncLine;
  } fsm_sel_t;
endpackage

// ---- fsm_sample_ram.sv ----
// eight-word sample store with registered read data
`include "fsm_map.svh"
module fsm_sample_ram (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [`FSM_ADDR_W-1:0] wrAddr,
  input wire logic [`FSM_DATA_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [`FSM_ADDR_W-1:0] rdAddr,
  output logic [`FSM_DATA_W-1:0] rdData
);
  logic [`FSM_DATA_W-1:0] mem [`FSM_DEPTH];
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

// ---- fsm_fifo_clock_mode.sv ----
// input elastic fifo mode control, pointer alarms and sample clock source selection
// Operation
// R1 - fifo disabled: bypass, ignore read selection
// R2 - dual mode: enable, only output strobe selected
// R3 - dual: write from input, read from strobe
// R4 - single mode: bits 3,2 clear, one source; code also gives single with read bit 3 or 2 set, except output strobe alone
// R5 - single mode may skew outputs two cycles
// R6 - host gives one sync edge, not periodic
// R7 - single-mode slip happens only at sync
// R8 - separate collision, one-away, two-away alarms
// R9 - host retunes offset and resyncs on alarm
// R10 - bypass: pointers do not affect data
// R11 - converter clock core, data clock writes
// R12 - pll off and asleep: pin clock
// R13 - pll on and awake: multiplied clock
// R14 - host keeps prescale product in vco range
// R15 - prescaler codes 111..100 mean 7..4
// R16 - m divider plain binary ratio
// R17 - host keeps prescale times m 24..480
// R18 - host keeps phase detector under 155 MHz
// R19 - charge pump code 01 selects single
// R20 - six-bit coarse tune drives oscillator centre
// R21 - pll makes output strobe from n divider
// R22 - both selections zero: no pointer resets
// R23 - host paces output strobes by 8 multiples
// R24 - sync: write to 0, read to offset
// R25 - compare pointers every read for alarms
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`include "fsm_map.svh"
module fsm_fifo_clock_mode (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic inputWordStrobe,
  input wire logic [`FSM_DATA_W-1:0] inputWordData,
  input wire logic inputPhaseStrobe,
  input wire logic syncLine,
  input wire logic outputPhaseStrobe,
  input wire logic readStrobe,
  output logic [`FSM_DATA_W-1:0] sampleOut,
  output logic usePllClock,
  output logic pllAsleep,
  output logic [2:0] pllPrescale,
  output logic [7:0] pllMDivide,
  output logic [1:0] chargePumpCurrent,
  output logic [5:0] vcoCoarseTune,
  output logic fsmAlarm
);
  logic [31:0] ctrlA_ff, nxt_ctrlA, ctrlB_ff, nxt_ctrlB, ctrlC_ff, nxt_ctrlC, ctrlD_ff, nxt_ctrlD;
  logic [7:0] addrQ_ff, nxt_addrQ;
  logic wrQ_ff, nxt_wrQ, rdQ_ff, nxt_rdQ;
  logic sifPulse;
  logic [2:0] inSync_ff, outSync_ff, lineSync_ff;
  logic [2:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [1:0] hand_ff, nxt_hand;
  logic [7:0] nCount_ff, nxt_nCount;
  logic pllStrobe_ff, nxt_pllStrobe;
  fsm_pkg::fsm_alarm_t alarm_ff, nxt_alarm;
  logic [`FSM_DATA_W-1:0] bypass_ff, nxt_bypass, ramData;
  fsm_pkg::fsm_mode_t mode;
  fsm_pkg::fsm_sel_t inSel, outSel;
  logic inEdge, outEdge, lineEdge, wrReset, rdReset, writeNow, readNow;
  logic [2:0] offset;

  // gap from write to read pointer modulo the depth
  function automatic logic [2:0] ptrGap(input logic [2:0] wr, input logic [2:0] rd);
    ptrGap = 3'(wr - rd);
  endfunction

  // prescale code to divide value
  function automatic logic [2:0] preValue(input logic [2:0] code);
    preValue = code[2] ? code : 3'h4;
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    nxt_ctrlA = ctrlA_ff;
    nxt_ctrlB = ctrlB_ff;
    nxt_ctrlC = ctrlC_ff;
    nxt_ctrlD = ctrlD_ff;
    nxt_addrQ = addrQ_ff;
    nxt_wrQ = 1'b0;
    nxt_rdQ = 1'b0;
    sifPulse = 1'b0;
    if (hready) begin
      nxt_addrQ = haddr[7:0];
      nxt_wrQ = hsel && htrans[1] && hwrite;
      nxt_rdQ = hsel && htrans[1] && !hwrite;
    end
    if (wrQ_ff) begin
      case (addrQ_ff)
        `FSM_OFS_CTRL_A: nxt_ctrlA = hwdata & 32'h0000_0071;
        `FSM_OFS_CTRL_B: nxt_ctrlB = hwdata & 32'h00FF_0731;
        `FSM_OFS_CTRL_C: nxt_ctrlC = hwdata & 32'h00FF_3F01;
        `FSM_OFS_CTRL_D: nxt_ctrlD = hwdata & 32'h0000_00FF;
        `FSM_OFS_SYNC: sifPulse = hwdata[0];
        default: sifPulse = 1'b0;
      endcase
    end
  end

  always_comb begin
    hrdata = 32'h0000_0000;
    if (rdQ_ff) begin
      case (addrQ_ff)
        `FSM_OFS_CTRL_A: hrdata = ctrlA_ff;
        `FSM_OFS_CTRL_B: hrdata = ctrlB_ff;
        `FSM_OFS_CTRL_C: hrdata = ctrlC_ff;
        `FSM_OFS_CTRL_D: hrdata = ctrlD_ff;
        `FSM_OFS_STATUS: hrdata = {25'h0, usePllClock, 2'(mode), 1'b0,
          alarm_ff.twoAway, alarm_ff.oneAway, alarm_ff.collision};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlA_ff <= `FSM_A_RESET;
      ctrlB_ff <= `FSM_B_RESET;
      ctrlC_ff <= `FSM_C_RESET;
      ctrlD_ff <= `FSM_D_RESET;
      addrQ_ff <= 8'h00;
      wrQ_ff <= 1'b0;
      rdQ_ff <= 1'b0;
    end else if (clkEn) begin
      ctrlA_ff <= nxt_ctrlA;
      ctrlB_ff <= nxt_ctrlB;
      ctrlC_ff <= nxt_ctrlC;
      ctrlD_ff <= nxt_ctrlD;
      addrQ_ff <= nxt_addrQ;
      wrQ_ff <= nxt_wrQ;
      rdQ_ff <= nxt_rdQ;
    end
  end

  // pin strobes pass two flops; the third stage only feeds edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inSync_ff <= 3'h0;
      outSync_ff <= 3'h0;
      lineSync_ff <= 3'h0;
    end else if (clkEn) begin
      inSync_ff <= {inSync_ff[1:0], inputPhaseStrobe};
      outSync_ff <= {outSync_ff[1:0], outputPhaseStrobe};
      lineSync_ff <= {lineSync_ff[1:0], syncLine};
    end
  end

  assign inEdge = inSync_ff[1] && !inSync_ff[2];
  assign outEdge = outSync_ff[1] && !outSync_ff[2];
  assign lineEdge = lineSync_ff[1] && !lineSync_ff[2];
  assign inSel = fsm_pkg::fsm_sel_t'(ctrlD_ff[`FSM_D_IN_HI:`FSM_D_IN_LO]);
  assign outSel = fsm_pkg::fsm_sel_t'(ctrlD_ff[`FSM_D_OUT_HI:`FSM_D_OUT_LO]);
  assign offset = ctrlA_ff[`FSM_A_OFFSET_HI:`FSM_A_OFFSET_LO];

  always_comb begin
    if (!ctrlA_ff[`FSM_A_FIFO_ENA]) begin
      mode = fsm_pkg::FsmBypass; // R1
    end else if (outSel == 4'h0 && inSel == 4'h0) begin
      mode = fsm_pkg::FsmNoSync; // R22
    end else if (outSel.outStrobe && !outSel.sif && !outSel.inStrobe && !outSel.syncLine) begin
      mode = fsm_pkg::FsmDual; // R2
    end else begin
      mode = fsm_pkg::FsmSingle; // R4
    end
  end

  assign usePllClock = ctrlB_ff[`FSM_B_PLL_ENA] && !ctrlC_ff[`FSM_C_PLL_SLEEP]; // R12 R13
  assign pllAsleep = ctrlC_ff[`FSM_C_PLL_SLEEP]; // R12
  assign pllPrescale = preValue(ctrlB_ff[`FSM_B_PRE_HI:`FSM_B_PRE_LO]); // R15
  assign pllMDivide = ctrlB_ff[`FSM_B_M_HI:`FSM_B_M_LO]; // R16
  assign chargePumpCurrent = ctrlB_ff[`FSM_B_CP_HI:`FSM_B_CP_LO]; // R19
  assign vcoCoarseTune = ctrlC_ff[`FSM_C_VCO_HI:`FSM_C_VCO_LO]; // R20

  always_comb begin
    wrReset = (inSel.inStrobe && inEdge) || (inSel.syncLine && lineEdge)
      || (inSel.sif && sifPulse);
    rdReset = 1'b0;
    case (mode)
      // R3
      fsm_pkg::FsmDual: rdReset = usePllClock ? pllStrobe_ff : outEdge;
      // single mode delays the write reset two cycles through hand_ff
      fsm_pkg::FsmSingle: rdReset = hand_ff[1]; // R4 R5 R7
      fsm_pkg::FsmNoSync: rdReset = 1'b0;
      default: rdReset = 1'b0;
    endcase
    if (mode == fsm_pkg::FsmNoSync || mode == fsm_pkg::FsmBypass) begin
      wrReset = 1'b0; // R22
    end
    nxt_hand = {hand_ff[0], wrReset};
    writeNow = inputWordStrobe && mode != fsm_pkg::FsmBypass; // R11
    readNow = readStrobe && mode != fsm_pkg::FsmBypass;
    nxt_wrPtr = wrReset ? 3'h0 : (writeNow ? 3'(wrPtr_ff + 3'h1) : wrPtr_ff); // R24
    nxt_rdPtr = rdReset ? offset : (readNow ? 3'(rdPtr_ff + 3'h1) : rdPtr_ff); // R24
    nxt_alarm = alarm_ff;
    // resync clears alarms, but a hit in the same cycle still wins
    if (rdReset) begin
      nxt_alarm = '0;
    end
    if (readNow) begin
      nxt_alarm.collision = nxt_alarm.collision || ptrGap(wrPtr_ff, rdPtr_ff) == 3'h0; // R25 R8
      nxt_alarm.oneAway = nxt_alarm.oneAway || ptrGap(wrPtr_ff, rdPtr_ff) == 3'h1; // R8
      nxt_alarm.twoAway = nxt_alarm.twoAway || ptrGap(wrPtr_ff, rdPtr_ff) == 3'h2; // R8
    end
    nxt_bypass = readStrobe ? inputWordData : bypass_ff; // R10
    // R21
    nxt_nCount = (nCount_ff >= ctrlC_ff[`FSM_C_N_HI:`FSM_C_N_LO]) ? 8'h00 : 8'(nCount_ff + 8'h01);
    nxt_pllStrobe = usePllClock && nCount_ff == 8'h00;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_ff <= 3'h0;
      rdPtr_ff <= 3'h4;
      hand_ff <= 2'h0;
      alarm_ff <= '0;
      bypass_ff <= '0;
      nCount_ff <= 8'h00;
      pllStrobe_ff <= 1'b0;
    end else if (clkEn) begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      hand_ff <= nxt_hand;
      alarm_ff <= nxt_alarm;
      bypass_ff <= nxt_bypass;
      nCount_ff <= nxt_nCount;
      pllStrobe_ff <= nxt_pllStrobe;
    end
  end

  fsm_sample_ram u_fsm_sample_ram (
    .clk(clk),
    .wrEn(clkEn && writeNow),
    .wrAddr(wrPtr_ff),
    .wrData(inputWordData),
    .rdEn(clkEn && readNow),
    .rdAddr(rdPtr_ff),
    .rdData(ramData)
  );

  // ram output is unknown until first read; bypass path covers fifo-off use
  assign sampleOut = (mode == fsm_pkg::FsmBypass) ? bypass_ff : ramData; // R10
  assign fsmAlarm = alarm_ff.collision || alarm_ff.oneAway || alarm_ff.twoAway;
endmodule

// ---- fsm_fifo_clock_mode_checker.sv ----
// port assertions for the fifo/clock mode block
`include "fsm_map.svh"
module fsm_fifo_clock_mode_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [`FSM_DATA_W-1:0] sampleOut,
  input wire logic usePllClock,
  input wire logic pllAsleep,
  input wire logic [2:0] pllPrescale,
  input wire logic [7:0] pllMDivide,
  input wire logic [1:0] chargePumpCurrent,
  input wire logic [5:0] vcoCoarseTune,
  input wire logic fsmAlarm
);
  logic wrB_ff, wrC_ff, nxt_wrB, nxt_wrC, take;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_comb begin
    take = hsel & htrans[1] & hwrite & hready & clkEn;
    nxt_wrB = take & (haddr[7:0] == `FSM_OFS_CTRL_B);
    nxt_wrC = take & (haddr[7:0] == `FSM_OFS_CTRL_C);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrB_ff <= 1'h0;
      wrC_ff <= 1'h0;
    end else begin
      wrB_ff <= nxt_wrB;
      wrC_ff <= nxt_wrC;
    end
  end
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_pll_awake: assert property (usePllClock |-> !pllAsleep) else $error("pll used asleep");
  a_prescale_range: assert property (pllPrescale >= 3'h4) else $error("prescale low");
  a_reset_values: assert property ($rose(reset_n) |-> pllPrescale == 3'h7 && pllMDivide == 8'h04
    && chargePumpCurrent == 2'h1 && pllAsleep && !usePllClock && !fsmAlarm)
    else $error("bad reset outputs");
  a_freeze_state: assert property (!clkEn |=> $stable(sampleOut) && $stable(fsmAlarm))
    else $error("state moved while frozen");
  a_b_write: assert property (wrB_ff && clkEn |=> pllMDivide == $past(hwdata[23:16])
    && chargePumpCurrent == $past(hwdata[5:4])
    && pllPrescale == ($past(hwdata[10]) ? $past(hwdata[10:8]) : 3'h4))
    else $error("pll divider fields wrong");
  a_c_write: assert property (wrC_ff && clkEn |=> vcoCoarseTune == $past(hwdata[13:8])
    && pllAsleep == $past(hwdata[0])) else $error("coarse tune or sleep wrong");
endmodule

// ---- fsm_baseband_model.sv ----
// baseband source: sample words and sync pulses toward the block
module fsm_baseband_model (
  input wire logic clk,
  input wire logic runWords,
  input wire logic [63:0] word,
  input wire logic [2:0] pulseReq,
  output logic inputWordStrobe,
  output logic [63:0] inputWordData,
  output logic inputPhaseStrobe,
  output logic syncLine,
  output logic outputPhaseStrobe
);
  initial begin
    inputWordStrobe = 1'h0;
    inputWordData = 64'h0;
    {outputPhaseStrobe, inputPhaseStrobe, syncLine} = 3'h0;
  end
  always @(posedge clk) begin
    inputWordStrobe <= runWords;
    // unqualified data keeps toggling so a stale word never looks valid
    inputWordData <= runWords ? word : ~inputWordData;
    {outputPhaseStrobe, inputPhaseStrobe, syncLine} <= pulseReq;
  end
endmodule

// ---- fsm_fifo_clock_mode_bench.sv ----
// self-checking bench for the fifo/clock mode block
`include "fsm_map.svh"
module fsm_fifo_clock_mode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // clock enable stays high through reset so frozen-state checks never see the unread store
  logic clk = 0, reset_n = 0, clkEn = 1, hsel = 0, hwrite = 0, readStrobe = 0, runWords = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, qExp[$], qMask[$];
  logic [1:0] htrans = 0, chargePumpCurrent;
  logic [2:0] hsize = 0, pulseReq = 0, pllPrescale;
  logic [63:0] word = 0, hold, inputWordData, sampleOut;
  logic [7:0] pllMDivide, dSel[3] = '{8'h24, 8'h21, 8'h00};
  logic [5:0] vcoCoarseTune;
  logic hreadyout, hresp, usePllClock, pllAsleep, fsmAlarm, rdPhase = 0;
  logic inputWordStrobe, inputPhaseStrobe, syncLine, outputPhaseStrobe;
  int n_fail = 0, n_checks = 0, dMode[3] = '{2, 1, 3};
  always #20 clk = ~clk;
  fsm_baseband_model u_fsm_baseband_model (.clk, .runWords, .word, .pulseReq, .inputWordStrobe,
    .inputWordData, .inputPhaseStrobe, .syncLine, .outputPhaseStrobe);
  fsm_fifo_clock_mode u_fsm_fifo_clock_mode (.clk, .reset_n, .clkEn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .inputWordStrobe,
    .inputWordData, .inputPhaseStrobe, .syncLine, .outputPhaseStrobe, .readStrobe, .sampleOut,
    .usePllClock, .pllAsleep, .pllPrescale, .pllMDivide, .chargePumpCurrent, .vcoCoarseTune,
    .fsmAlarm);
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'h2;
    if (!w) begin
      qExp.push_back(d);
      qMask.push_back(m);
    end
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    @(negedge clk);
  endtask
  task sync(input logic [2:0] s);
    pulseReq <= s;
    repeat (2) @(posedge clk);
    pulseReq <= 3'h0;
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask
  task drain(input int n);
    @(posedge clk);
    readStrobe <= 1;
    repeat (n) @(posedge clk);
    readStrobe <= 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  // read data is judged in the data phase, against the oldest note
  always @(posedge clk) begin
    if (rdPhase && hreadyout === 1'h1) begin
      n_checks++;
      if ((hrdata & qMask[0]) !== (qExp[0] & qMask[0])) begin
        n_fail++;
        $display("MISMATCH t=%0t got %h exp %h", $time, hrdata, qExp[0]);
      end
      qExp.pop_front();
      qMask.pop_front();
    end
    rdPhase <= hsel & htrans[1] & !hwrite & hreadyout;
  end
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
  initial begin
    void'($urandom(49));
    repeat (4) @(posedge clk);
    reset_n <= 1;
    clkEn <= 1;
    bus(0, `FSM_OFS_CTRL_A, `FSM_A_RESET, 32'h71);
    bus(0, `FSM_OFS_CTRL_B, `FSM_B_RESET, 32'hFF0731);
    bus(0, `FSM_OFS_CTRL_C, `FSM_C_RESET, 32'hFF3F01);
    bus(0, `FSM_OFS_CTRL_D, `FSM_D_RESET, 32'hFF);
    bus(0, `FSM_OFS_STATUS, 32'h10, 32'h70);
    bus(1, 32'h20, 32'hFFFFFFFF, 0);
    bus(0, 32'h20, 0, 32'hFFFFFFFF);
    $display("reset values done");
    bus(1, `FSM_OFS_CTRL_A, 32'h40, 0);
    bus(1, `FSM_OFS_CTRL_D, {24'h0, 4'h2, 4'($urandom)}, 0);
    bus(0, `FSM_OFS_STATUS, 32'h0, 32'h30);
    bus(1, `FSM_OFS_CTRL_A, 32'h41, 0);
    for (int i = 0; i < 3; i++) begin
      bus(1, `FSM_OFS_CTRL_D, dSel[i], 0);
      bus(0, `FSM_OFS_STATUS, 32'(dMode[i]) << 4, 32'h30);
    end
    $display("fifo modes done");
    bus(1, `FSM_OFS_CTRL_C, 32'h12A00, 0);
    for (int p = 3; p < 8; p++) begin
      // product of prescale and m stays inside 24..480
      bus(1, `FSM_OFS_CTRL_B, 32'h80011 | (p << 8), 0);
      chk(pllPrescale, (p < 4) ? 4 : p);
    end
    chk({usePllClock, pllMDivide, chargePumpCurrent}, {1'h1, 8'h08, 2'h1});
    chk(vcoCoarseTune, 6'h2A);
    bus(0, `FSM_OFS_STATUS, 32'h40, 32'h40);
    bus(1, `FSM_OFS_CTRL_C, 32'h12A01, 0);
    chk({usePllClock, pllAsleep}, 2'h1);
    $display("clock source done");
    bus(1, `FSM_OFS_CTRL_A, 32'h40, 0);
    @(posedge clk);
    word <= {$urandom, $urandom};
    runWords <= 1;
    readStrobe <= 1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk(sampleOut, word);
    hold = word;
    @(posedge clk);
    clkEn <= 0;
    word <= ~word;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(sampleOut, hold);
    @(posedge clk);
    clkEn <= 1;
    runWords <= 0;
    readStrobe <= 0;
    $display("bypass done");
    bus(1, `FSM_OFS_CTRL_A, 32'h41, 0);
    bus(1, `FSM_OFS_CTRL_D, 32'h22, 0);
    sync(3'h2);
    runWords <= 1;
    @(posedge clk);
    readStrobe <= 1;
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(fsmAlarm, 0);
    chk(sampleOut, word);
    runWords <= 0;
    repeat (8) @(posedge clk);
    readStrobe <= 0;
    @(negedge clk);
    chk(fsmAlarm, 1);
    bus(0, `FSM_OFS_STATUS, 32'h07, 32'h07);
    // an alarm is answered by a fresh sync
    sync(3'h2);
    chk(fsmAlarm, 0);
    $display("single mode done");
    bus(1, `FSM_OFS_CTRL_D, 32'h24, 0);
    drain(8);
    chk(fsmAlarm, 1);
    sync(3'h2);
    chk(fsmAlarm, 1);
    sync(3'h4);
    chk(fsmAlarm, 0);
    bus(1, `FSM_OFS_CTRL_D, 32'h00, 0);
    drain(8);
    sync(3'h7);
    chk(fsmAlarm, 1);
    // pll awake in dual mode: its own strobe keeps pulling the read pointer back
    bus(1, `FSM_OFS_CTRL_C, 32'h12A00, 0);
    bus(1, `FSM_OFS_CTRL_D, 32'h24, 0);
    drain(8);
    chk(fsmAlarm, 0);
    bus(1, `FSM_OFS_CTRL_D, 32'h88, 0);
    drain(8);
    chk(fsmAlarm, 1);
    bus(1, `FSM_OFS_SYNC, 32'h1, 0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(fsmAlarm, 0);
    $display("dual mode done");
    conclude();
  end
endmodule
bind fsm_fifo_clock_mode fsm_fifo_clock_mode_checker u_fsm_fifo_clock_mode_checker (.clk,
  .reset_n, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .sampleOut, .usePllClock, .pllAsleep, .pllPrescale, .pllMDivide, .chargePumpCurrent,
  .vcoCoarseTune, .fsmAlarm);
